// *** rtl/dcl_pkg.sv ***
// dcl_pkg: constants and types of the driver configuration, clear and lock block
`default_nettype none
package dcl_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned DEGLITCH_SHORT_NS = 3500;
  localparam int unsigned DEGLITCH_LONG_NS = 10000;
  localparam int unsigned RETRY_MS = 100;
  // least times round up, none below one cycle
  localparam int unsigned DEGLITCH_SHORT_CYC =
    (DEGLITCH_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEGLITCH_LONG_CYC =
    (DEGLITCH_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RETRY_CYC = (RETRY_MS * 1000000) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register numbers carried in a command word
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CHANNEL_ON = 4'h8;
  localparam logic [3:0] REG_OCP_MASK = 4'h9;
  localparam logic [3:0] REG_OPEN_MASK = 4'hA;
  localparam logic [3:0] REG_CONFIG = 4'hB;
  localparam logic [3:0] REG_MAP_CLEAR = 4'hC;
  localparam logic [3:0] REG_SPARE = 4'hD;
  localparam logic [3:0] REG_LOCK = 4'hE;
  localparam logic [3:0] REG_FLAG_CLEAR = 4'hF;

  // ----------------------------------------------------------------
  // field positions, keys and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CFG_FRAME_CHECK = 3;
  localparam int unsigned CFG_RETRY = 4;
  localparam int unsigned CFG_MAPPING = 5;
  localparam int unsigned CFG_LONG_DEGLITCH = 6;
  localparam int unsigned CFG_FORCE_FAULT = 7;
  localparam int unsigned CLR_POWERUP = 0;
  localparam int unsigned CLR_GLOBAL = 1;
  localparam int unsigned OPEN_LOAD_CLEAR = 2;
  localparam int unsigned OVERCURRENT_CLEAR = 3;
  localparam int unsigned CLR_THERMAL = 4;
  localparam logic [7:0] MAP_CLEAR_KEY = 8'hA6;
  localparam logic [7:0] LOCK_KEY = 8'h31;
  localparam logic [7:0] UNLOCK_KEY = 8'h95;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] CONFIG_WRITE_MASK = 8'h78;
  localparam logic [3:0] CRC_POLY = 4'h3;
  localparam int unsigned FRAME_BITS = 16;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
    logic [3:0] crc;
  } dcl_cmd_t;

  typedef struct packed {
    logic powerup;
    logic forced;
    logic comm_error;
    logic thermal;
    logic [7:0] open_load;
    logic [7:0] overcurrent;
  } dcl_flags_t;

  // 4-bit check code over address and data, msb first, zero seed
  function automatic logic [3:0] dcl_crc4(input logic [11:0] msg);
    logic [3:0] c;
    logic fb;
    c = 4'h0;
    for (int i = 11; i >= 0; i--) begin
      fb = msg[i] ^ c[3];
      c = {c[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
    end
    return c;
  endfunction

endpackage
`default_nettype wire

// *** rtl/dcl_driver_config.sv ***
// dcl_driver_config: serial command receiver, config, clear and lock logic
//
// Summary of operation
// - mask bits of channels five to eight switch their open-load detection off
// - check enable on: bad check code flags error and drops frame
// - retry select off keeps over-current shutdown; on re-enables all shut channels 100ms after the first trip
// - mapping off: pulses drive channels 1-4; on: pulses reach all eight
// - over-current deglitch is 3.5us, or 10us with long deglitch select
// - forced-fault bit self-clears, leaves latched fault until global clear
// - byte A6 to the map-clear register restores the channel, mask, configuration and lock registers; fault flags stay
// - byte 31 to the lock register blocks writes to other registers
// - byte 95 to the lock register lifts the write protection
// - powerup clear bit clears the powerup flag and self-clears
// - global clear bit clears every fault flag except powerup and self-clears
// - open-load clear bit clears open-load flags and self-clears
// - over-current clear bit clears over-current flags and self-clears
// - thermal clear bit clears the thermal flag and self-clears
// - word 8012 switches on channel one only
// - word 8FF5 switches on all eight channels
// - word 8001 switches off all eight channels
// - each channel control bit turns its channel on at one
// - mask bits of channels one to four switch open-load detection off
`default_nettype none
module dcl_driver_config
  import dcl_pkg::*;
#(
  parameter int unsigned RETRY_CYCLES = RETRY_CYC
) (
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial link from the host
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  // analog side inputs, asynchronous
  input wire logic [3:0] pulse_inputs,
  input wire logic [7:0] open_load_detect,
  input wire logic [7:0] overcurrent_detect,
  input wire logic thermal_shutdown,
  // channel drive and detection controls
  output logic [7:0] driver_outputs,
  output logic [7:0] open_load_mask,
  output logic [7:0] overcurrent_mask,
  // status
  output dcl_flags_t fault_flags,
  output logic write_protected
);

  // ----------------------------------------------------------------
  // link domain: shift in sixteen bits per frame
  // ----------------------------------------------------------------
  logic [3:0] bit_cnt_q, bit_cnt_d;
  logic [14:0] shift_q, shift_d;
  dcl_cmd_t frame_q, frame_d;
  logic frame_tgl_q, frame_tgl_d;

  // word complete on sixteenth edge; frame held until the next word
  // the count wraps after sixteen, so a long frame starts a new word
  always_comb begin
    bit_cnt_d = bit_cnt_q + 4'h1;
    shift_d = {shift_q[13:0], spi_mosi};
    frame_d = frame_q;
    frame_tgl_d = frame_tgl_q;
    if (bit_cnt_q == 4'(FRAME_BITS - 1)) begin
      frame_d = {shift_q, spi_mosi};
      frame_tgl_d = ~frame_tgl_q;
    end
  end

  // a cut frame leaves no stray bits; the next word starts at bit zero
  // bit counter restarts whenever select is released
  always_ff @(posedge spi_sclk or posedge rst or posedge spi_cs_n) begin
    if (rst || spi_cs_n) begin
      bit_cnt_q <= 4'h0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
    end
  end

  // data registers survive deselect; the word must stay put for the core
  always_ff @(posedge spi_sclk or posedge rst) begin
    if (rst) begin
      shift_q <= 15'h0000;
      frame_q <= '0;
      frame_tgl_q <= 1'b0;
    end else begin
      shift_q <= shift_d;
      frame_q <= frame_d;
      frame_tgl_q <= frame_tgl_d;
    end
  end

  // ----------------------------------------------------------------
  // core domain: synchronisers
  // ----------------------------------------------------------------
  logic [21:0] sync1_q, sync2_q;
  logic tgl_seen_q;
  logic [3:0] pulse_s;
  logic [7:0] open_s;
  logic [7:0] ocp_s;
  logic therm_s;
  logic tgl_s;

  // two flops on every pin and on the frame toggle
  // pins are sampled as a bundle but each bit settles on its own
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 22'h000000;
      sync2_q <= 22'h000000;
      tgl_seen_q <= 1'b0;
    end else begin
      sync1_q <= {frame_tgl_q, thermal_shutdown, overcurrent_detect,
                  open_load_detect, pulse_inputs};
      sync2_q <= sync1_q;
      tgl_seen_q <= tgl_s;
    end
  end

  // only the toggle crosses; the word is read three core cycles later,
  // long after it settled, so it needs no synchroniser of its own
  assign {tgl_s, therm_s, ocp_s, open_s, pulse_s} = sync2_q;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic frame_evt;
  logic crc_ok;
  logic frame_ok;
  logic wr_ok;
  // register state sits here because the decode below reads it
  logic [7:0] chan_on_q, chan_on_d;
  logic [7:0] ocp_mask_q, ocp_mask_d;
  logic [7:0] open_mask_q, open_mask_d;
  logic [7:0] cfg_q, cfg_d;
  logic lock_q, lock_d;
  logic [7:0] clr_q, clr_d;
  logic force_q, force_d;

  // frame_q is stable at least sixteen link clocks past the toggle
  assign frame_evt = tgl_s ^ tgl_seen_q;
  // computed every cycle; only a frame event lets it count
  assign crc_ok = (dcl_crc4({frame_q.addr, frame_q.data}) == frame_q.crc);
  // mismatches pass untouched while checking is off
  assign frame_ok = crc_ok || !cfg_q[CFG_FRAME_CHECK];
  // lock register stays writable so the map can always be unlocked
  // a map clear counts as a write, so it is refused while locked
  assign wr_ok = frame_evt && frame_ok && frame_q.addr[3] &&
                 (!lock_q || frame_q.addr == REG_LOCK);

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------

  // writes; clear and force bits live one cycle only
  always_comb begin
    chan_on_d = chan_on_q;
    ocp_mask_d = ocp_mask_q;
    open_mask_d = open_mask_q;
    cfg_d = cfg_q;
    lock_d = lock_q;
    // clear pulses last one core cycle after the write lands
    clr_d = 8'h00;
    force_d = 1'b0;
    if (wr_ok) begin
      case (frame_q.addr)
        REG_CHANNEL_ON: chan_on_d = frame_q.data;
        REG_OCP_MASK: ocp_mask_d = frame_q.data;
        REG_OPEN_MASK: open_mask_d = frame_q.data;
        REG_CONFIG: begin
          // low three bits are reserved and dropped
          cfg_d = frame_q.data & CONFIG_WRITE_MASK;
          force_d = frame_q.data[CFG_FORCE_FAULT];
        end
        // flags stay; channel, mask, configuration and lock registers go back to reset
        REG_MAP_CLEAR: begin
          if (frame_q.data == MAP_CLEAR_KEY) begin
            chan_on_d = REG_RESET;
            ocp_mask_d = REG_RESET;
            open_mask_d = REG_RESET;
            cfg_d = REG_RESET;
            lock_d = 1'b0;
          end
        end
        // any other byte leaves the lock state as it was
        REG_LOCK: begin
          if (frame_q.data == LOCK_KEY) begin
            lock_d = 1'b1;
          end else if (frame_q.data == UNLOCK_KEY) begin
            lock_d = 1'b0;
          end
        end
        REG_FLAG_CLEAR: clr_d = {3'b000, frame_q.data[4:0]};
        default: ; // spare register and read numbers do nothing here
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      chan_on_q <= REG_RESET;
      ocp_mask_q <= REG_RESET;
      open_mask_q <= REG_RESET;
      cfg_q <= REG_RESET;
      lock_q <= 1'b0;
      clr_q <= 8'h00;
      force_q <= 1'b0;
    end else begin
      chan_on_q <= chan_on_d;
      ocp_mask_q <= ocp_mask_d;
      open_mask_q <= open_mask_d;
      cfg_q <= cfg_d;
      lock_q <= lock_d;
      clr_q <= clr_d;
      force_q <= force_d;
    end
  end

  // ----------------------------------------------------------------
  // over-current deglitch, shutdown and retry
  // ----------------------------------------------------------------
  logic [7:0] dg_q [8];
  logic [7:0] dg_d [8];
  logic [7:0] ocp_trip;
  logic [7:0] shut_q, shut_d;
  logic [31:0] retry_q, retry_d;
  logic [7:0] dg_limit;
  logic retry_done;

  // limit picked live so a config change takes effect at once
  // (a count already past the new limit trips on the next sample)
  assign dg_limit = cfg_q[CFG_LONG_DEGLITCH] ?
                    8'(DEGLITCH_LONG_CYC) : 8'(DEGLITCH_SHORT_CYC);
  // the timer is back at zero within one cycle of nothing being shut down
  assign retry_done = (retry_q == RETRY_CYCLES - 1);

  // trip after the fault stood unbroken for the whole deglitch time
  // a single quiet sample restarts the count, so chatter never trips
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      dg_d[i] = 8'h00;
      ocp_trip[i] = 1'b0;
      if (ocp_s[i] && !ocp_mask_q[i]) begin
        if (dg_q[i] >= dg_limit - 8'h01) begin
          dg_d[i] = dg_limit - 8'h01;
          ocp_trip[i] = 1'b1;
        end else begin
          dg_d[i] = dg_q[i] + 8'h01;
        end
      end
    end
  end

  // one shared retry timer: restarts all tripped channels together
  // trade-off: one timer is small, but a channel that trips late may
  // be released before its own full retry time has passed
  always_comb begin
    retry_d = 32'h00000000;
    shut_d = shut_q;
    if (cfg_q[CFG_RETRY] && shut_q != 8'h00) begin
      retry_d = retry_q + 32'h00000001;
      if (retry_done) begin
        retry_d = 32'h00000000;
        shut_d = 8'h00;
      end
    end
    if (clr_q[CLR_GLOBAL] || clr_q[OVERCURRENT_CLEAR]) begin
      shut_d = 8'h00;
    end
    // a trip in the same cycle wins over any release
    shut_d = shut_d | ocp_trip;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        dg_q[i] <= 8'h00;
      end
      shut_q <= 8'h00;
      retry_q <= 32'h00000000;
    end else begin
      for (int i = 0; i < 8; i++) begin
        dg_q[i] <= dg_d[i];
      end
      shut_q <= shut_d;
      retry_q <= retry_d;
    end
  end

  // ----------------------------------------------------------------
  // sticky fault flags
  // ----------------------------------------------------------------
  dcl_flags_t flags_q, flags_d;

  // clears first, then sets, so an event in the clear cycle stays
  always_comb begin
    flags_d = flags_q;
    if (clr_q[CLR_POWERUP]) begin
      flags_d.powerup = 1'b0;
    end
    if (clr_q[CLR_GLOBAL]) begin
      flags_d.forced = 1'b0;
      flags_d.comm_error = 1'b0;
      flags_d.thermal = 1'b0;
      flags_d.open_load = 8'h00;
      flags_d.overcurrent = 8'h00;
    end
    if (clr_q[OPEN_LOAD_CLEAR]) begin
      flags_d.open_load = 8'h00;
    end
    if (clr_q[OVERCURRENT_CLEAR]) begin
      flags_d.overcurrent = 8'h00;
    end
    if (clr_q[CLR_THERMAL]) begin
      flags_d.thermal = 1'b0;
    end
    flags_d.forced = flags_d.forced | force_q;
    flags_d.comm_error = flags_d.comm_error |
                         (frame_evt && !crc_ok && cfg_q[CFG_FRAME_CHECK]);
    flags_d.thermal = flags_d.thermal | therm_s;
    flags_d.open_load = flags_d.open_load | (open_s & ~open_mask_q);
    flags_d.overcurrent = flags_d.overcurrent | ocp_trip;
  end

  // comm_error has no clear bit of its own; only the global clear drops it
  // powerup flag reads one out of reset until software clears it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flags_q <= '{powerup: 1'b1, default: '0};
    end else begin
      flags_q <= flags_d;
    end
  end

  // ----------------------------------------------------------------
  // channel drive and registered outputs
  // ----------------------------------------------------------------
  logic [7:0] pulse_map;
  logic [7:0] drive_d;
  logic [7:0] drive_q;

  // pulse inputs add to the register bits; a shutdown overrides both
  always_comb begin
    pulse_map = {4'h0, pulse_s};
    if (cfg_q[CFG_MAPPING]) begin
      pulse_map = {pulse_s, pulse_s};
    end
    drive_d = (chan_on_q | pulse_map) & ~shut_q;
    // hot die: every channel off, whatever the pulses or registers say
    if (therm_s) begin
      drive_d = 8'h00;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      drive_q <= 8'h00;
    end else begin
      drive_q <= drive_d;
    end
  end

  // nothing is decoded on the way out, so no glitch reaches a pin
  // masks, flags and lock state come straight from their flops
  assign driver_outputs = drive_q;
  assign open_load_mask = open_mask_q;
  assign overcurrent_mask = ocp_mask_q;
  assign fault_flags = flags_q;
  assign write_protected = lock_q;

endmodule
`default_nettype wire

// *** testbench/dcl_driver_config_props.sv ***
// dcl_driver_config_props: concurrent checks on the block's ports
`default_nettype none
module dcl_driver_config_props
  import dcl_pkg::*;
#(
  parameter int unsigned RETRY_CYCLES = RETRY_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // analog side
  input wire logic thermal_shutdown,
  input wire logic [7:0] open_load_detect,
  input wire logic [7:0] overcurrent_detect,
  // controls and status
  input wire logic [7:0] driver_outputs,
  input wire logic [7:0] open_load_mask,
  input wire logic [7:0] overcurrent_mask,
  input wire dcl_flags_t fault_flags,
  input wire logic write_protected
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------
  // helpers
  // ------
  localparam int OC_MIN = (3500 + 39) / 40;
  logic [9:0] oc_run_q, oc_run_d;
  // run length of unmasked over-current, saturating so it never wraps
  always_comb begin
    oc_run_d = 10'h000;
    if (|(overcurrent_detect & ~overcurrent_mask)) begin
      oc_run_d = (oc_run_q == 10'h3FF) ? oc_run_q : oc_run_q + 10'h001;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      oc_run_q <= 10'h000;
    end else begin
      oc_run_q <= oc_run_d;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // long enough for the pin synchroniser to settle
  sequence therm_seen;
    thermal_shutdown [*5];
  endsequence
  sequence open_seen;
    ((open_load_detect & ~open_load_mask) != 8'h00 &&
     $stable(open_load_mask)) [*5];
  endsequence
  // ------
  // properties
  // ------
  therm_flag_a: assert property (
    therm_seen |-> fault_flags.thermal) else $error("thermal flag missing");
  therm_off_a: assert property (
    therm_seen |-> driver_outputs == 8'h00) else $error("drive while hot");
  open_set_a: assert property (
    open_seen |-> (fault_flags.open_load & ~open_load_mask) != 8'h00)
    else $error("open flag missing");
  open_masked_a: assert property (
    (fault_flags.open_load & ~$past(fault_flags.open_load) &
     $past(open_load_mask)) == 8'h00) else $error("masked open flagged");
  ocp_deglitch_a: assert property (
    $rose(|fault_flags.overcurrent) |-> oc_run_q >= OC_MIN)
    else $error("over-current flagged too early");
  ocp_shut_a: assert property (
    $rose(fault_flags.overcurrent[0]) |-> ##[0:2] !driver_outputs[0])
    else $error("channel not shut off");
  lock_hold_a: assert property (
    write_protected && $past(write_protected) |->
    $stable(open_load_mask) && $stable(overcurrent_mask))
    else $error("write while locked");
  lock_space_a: assert property (
    $changed(write_protected) |=> $stable(write_protected) [*8])
    else $error("lock toggles too fast");
  powerup_stay_a: assert property (
    !fault_flags.powerup |=> !fault_flags.powerup)
    else $error("powerup flag came back");
endmodule
bind dcl_driver_config dcl_driver_config_props #(
  .RETRY_CYCLES(RETRY_CYCLES)) chk_u (
  .core_clk(core_clk), .rst(rst), .thermal_shutdown(thermal_shutdown),
  .open_load_detect(open_load_detect),
  .overcurrent_detect(overcurrent_detect), .driver_outputs(driver_outputs),
  .open_load_mask(open_load_mask), .overcurrent_mask(overcurrent_mask),
  .fault_flags(fault_flags), .write_protected(write_protected));
`default_nettype wire

// *** testbench/dcl_host_model.sv ***
// dcl_host_model: host side serial master sending command words
`default_nettype none
module dcl_host_model (
  // serial link to the device
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b1;
  end
  // one word per frame, msb first, 32 ns link clock idle low between
  task automatic send(input logic [15:0] w);
    #7;
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = w[i];
      #16;
      spi_sclk = 1'b1;
      #16;
      spi_sclk = 1'b0;
    end
    #16;
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi; // stale data must not look valid
  endtask
endmodule
`default_nettype wire

// *** testbench/dcl_driver_config_tb.sv ***
// dcl_driver_config_tb: self-checking bench for config, clear and lock
`default_nettype none
module dcl_driver_config_tb
  import dcl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int RETRY_T = 50;
  localparam int SHORT_C = (3500 + 39) / 40;
  localparam int LONG_C = (10000 + 39) / 40;
  logic core_clk, rst, spi_sclk, spi_cs_n, spi_mosi, thermal_shutdown;
  logic [3:0] pulse_inputs;
  logic [7:0] open_load_detect, overcurrent_detect, driver_outputs;
  logic [7:0] open_load_mask, overcurrent_mask;
  logic write_protected;
  dcl_flags_t fault_flags;
  int error_cnt, n_compared, n;
  dcl_host_model host_u (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi));
  dcl_driver_config #(.RETRY_CYCLES(RETRY_T)) dut_u (
    .core_clk(core_clk), .rst(rst), .spi_sclk(spi_sclk),
    .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .pulse_inputs(pulse_inputs),
    .open_load_detect(open_load_detect),
    .overcurrent_detect(overcurrent_detect),
    .thermal_shutdown(thermal_shutdown), .driver_outputs(driver_outputs),
    .open_load_mask(open_load_mask), .overcurrent_mask(overcurrent_mask),
    .fault_flags(fault_flags), .write_protected(write_protected));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // ------
  // tasks
  // ------
  function automatic logic [3:0] crc4(input logic [11:0] m);
    logic [3:0] c;
    c = 4'h0;
    for (int i = 11; i >= 0; i--) begin
      c = {c[2:0], 1'b0} ^ ((m[i] ^ c[3]) ? 4'h3 : 4'h0);
    end
    return c;
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // effect lands within 6 core cycles, so 8 is a safe settle
  task automatic send(input logic [15:0] w);
    host_u.send(w);
    repeat (8) @(negedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    send({a, d, crc4({a, d})});
  endtask
  task automatic summarize;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // cycles from raising channel one over-current to its flag
  task automatic oc_wait(input int lo, input int hi);
    n = 0;
    overcurrent_detect = 8'h01;
    while (fault_flags.overcurrent[0] !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    overcurrent_detect = 8'h00;
    chk(20'(n >= lo && n <= hi), 20'h1);
    if (n >= 400) summarize;
  endtask
  // ------
  // main sequence
  // ------
  initial begin
    rst = 1'b1;
    pulse_inputs = 4'h0;
    open_load_detect = 8'h00;
    overcurrent_detect = 8'h00;
    thermal_shutdown = 1'b0;
    error_cnt = 0;
    n_compared = 0;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk({driver_outputs, open_load_mask}, 16'h0);
    chk({overcurrent_mask, 3'h0, write_protected}, 12'h0);
    chk(fault_flags, 20'h80000);
    wr(4'hB, 8'h08);
    send(16'h8012);
    chk(driver_outputs, 8'h01);
    send(16'h8FF5);
    chk(driver_outputs, 8'hFF);
    send(16'h8001);
    chk(driver_outputs, 8'h00);
    chk(fault_flags.comm_error, 1'b0);
    wr(4'h8, 8'hA5);
    chk(driver_outputs, 8'hA5);
    wr(4'h9, 8'h3C);
    wr(4'hA, 8'hF0);
    chk({overcurrent_mask, open_load_mask}, 16'h3CF0);
    open_load_detect = 8'hFF;
    repeat (6) @(negedge core_clk);
    chk(fault_flags.open_load, 8'h0F);
    wr(4'hA, 8'h0F);
    chk(fault_flags.open_load, 8'hFF);
    open_load_detect = 8'h00;
    wr(4'hF, 8'h04);
    chk(fault_flags.open_load, 8'h00);
    wr(4'h8, 8'h00);
    pulse_inputs = 4'h5;
    repeat (6) @(negedge core_clk);
    chk(driver_outputs, 8'h05);
    wr(4'hB, 8'h20);
    chk(driver_outputs, 8'h55);
    pulse_inputs = 4'h0;
    wr(4'hB, 8'h08);
    send({12'h80F, crc4(12'h80F) ^ 4'h1});
    chk({driver_outputs, 3'h0, fault_flags.comm_error}, 12'h001);
    wr(4'hB, 8'h00);
    send({12'h80F, crc4(12'h80F) ^ 4'h1});
    chk(driver_outputs, 8'h0F);
    wr(4'hB, 8'h80);
    wr(4'h8, 8'hFF);
    chk(fault_flags.forced, 1'b1);
    thermal_shutdown = 1'b1;
    repeat (6) @(negedge core_clk);
    chk({driver_outputs, 3'h0, fault_flags.thermal}, 12'h001);
    thermal_shutdown = 1'b0;
    wr(4'hF, 8'h10);
    chk({driver_outputs, 3'h0, fault_flags.thermal}, 12'hFF0);
    wr(4'hF, 8'h02);
    chk(fault_flags, 20'h80000);
    wr(4'hF, 8'h01);
    chk(fault_flags, 20'h0);
    oc_wait(SHORT_C, SHORT_C + 6);
    repeat (RETRY_T + 20) @(negedge core_clk);
    chk(driver_outputs, 8'hFE);
    wr(4'hF, 8'h08);
    chk({driver_outputs, fault_flags.overcurrent}, 16'hFF00);
    wr(4'hB, 8'h50);
    oc_wait(LONG_C, LONG_C + 6);
    repeat (RETRY_T + 10) @(negedge core_clk);
    chk(driver_outputs, 8'hFF);
    wr(4'hE, 8'h31);
    wr(4'h8, 8'h00);
    wr(4'hC, 8'hA6);
    chk({driver_outputs, open_load_mask, 3'h0, write_protected},
      20'hFF0F1);
    wr(4'hE, 8'h95);
    wr(4'h8, 8'h12);
    chk({driver_outputs, 3'h0, write_protected}, 12'h120);
    wr(4'hC, 8'h11);
    chk(open_load_mask, 8'h0F);
    wr(4'hC, 8'hA6);
    chk({driver_outputs, open_load_mask, overcurrent_mask}, 24'h0);
    wr(4'hD, 8'hFF);
    wr(4'h3, 8'hFF);
    chk({driver_outputs, open_load_mask}, 16'h0);
    summarize;
  end
endmodule
`default_nettype wire
